// ---- common/char_regs_defs.svh ----
// constants for the characteristics register bank and its host port
`ifndef CHAR_REGS_DEFS_SVH
`define CHAR_REGS_DEFS_SVH
`define OFS_W 9
`define DAT_W 8
`define OFS_BUS_CAP 9'h000
`define OFS_DEV_TYPE 9'h001
`define OFS_LEGACY 9'h002
`define OFS_ODR 9'h003
`define OFS_INT_STATUS 9'h004
`define OFS_INT_ENABLE 9'h005
`define ROLE_HI 7
`define ROLE_LO 6
`define ROLE_SLAVE 2'h0
`define ROLE_MASTER 2'h1
`define BIT_HDR 5
`define BIT_BRIDGE 4
`define BIT_OFFLINE 3
`define BIT_IBI_PAYLOAD 2
`define BIT_IBI_REQ 1
`define BIT_SPEED_LIM 0
`define LEG_IDX_HI 7
`define LEG_IDX_LO 5
`define LEG_IDX_MAX 3'h2
`define LEG_MODE_BIT 4
`define DEV_TYPE_RST 8'h00
`define BUS_CAP_RST 8'h00
`define LEGACY_RST 8'h00
`define ODR_RST 8'h00
`define INT_RST 2'h0
`define EDGE_Q_RST 1'b1
`define INT_TX_EMPTY 0
`define INT_RX_FULL 1
`define BYTE_ZERO 8'h00
`endif

// ---- common/char_regs_pkg.sv ----
// state type used by the host end of the characteristics register port
`default_nettype none
package char_regs_pkg;
    typedef enum logic [1:0] {
        host_idle,
        host_wait_ready,
        host_wait_data
    } host_state_e;
endpackage : char_regs_pkg
`default_nettype wire

// ---- common/char_port_if.sv ----
// native request/ready register port joining host and device
`timescale 1ns/1ps
`default_nettype none
`include "char_regs_defs.svh"
interface char_port_if;
    logic request;
    logic wr_rdn;
    logic [`OFS_W-1:0] offset;
    logic [`DAT_W-1:0] wdata;
    logic [`DAT_W-1:0] rdata;
    logic rdata_valid;
    logic ready;
    logic irq;
    modport device (input request, wr_rdn, offset, wdata,
        output rdata, rdata_valid, ready, irq);
    modport host (output request, wr_rdn, offset, wdata,
        input rdata, rdata_valid, ready, irq);
endinterface : char_port_if
`default_nettype wire

// ---- rtl/char_regs_device.sv ----
// characteristics descriptor bank with native host port and interrupt
// Summary of operation
// - role bits 7:6, hdr-ddr capability bit 5
// - bit 4 marks a bridge device
// - bit 3 marks an offline-capable device
// - bit 2 says ibi carries payload bytes
// - bit 1 ibi capable, bit 0 speed limited
// - capability and type bytes read-only, exported
// - type byte is class code, default zero
// - legacy bits 7:5 index, above two reserved
// - legacy bit 4 picks fm; 3:0 reserved
// - legacy descriptors delivered before bus configured
// - host drives direction high write, low read
// - read valid pulses when read data valid
// - ready low means wait; host holds off
// - port reset restores every register default
// - interrupt level high while enabled event pending
// - nine offset bits and eight data bits
// - only the native host interface is built
// - eight-bit output data rate in ksps
// - interrupt on tx empty or rx full
`timescale 1ns/1ps
`default_nettype none
`include "char_regs_defs.svh"
module char_regs_device #(
    parameter logic [1:0] ROLE = `ROLE_MASTER,
    parameter logic HDR_CAPABLE = 1'b1,
    parameter logic IS_BRIDGE = 1'b0,
    parameter logic OFFLINE_CAPABLE = 1'b0,
    parameter logic IBI_PAYLOAD = 1'b1,
    parameter logic IBI_CAPABLE = 1'b1,
    parameter logic SPEED_LIMITED = 1'b1,
    parameter logic [7:0] DEVICE_TYPE = `DEV_TYPE_RST
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    char_port_if.device port,
    input wire logic [`DAT_W-1:0] legacy_descriptor_in,
    input wire logic legacy_load_in,
    input wire logic tx_empty_in,
    input wire logic rx_full_in,
    input wire logic [`DAT_W-1:0] output_data_rate_in,
    output logic [`DAT_W-1:0] bus_capability_out,
    output logic [`DAT_W-1:0] device_type_out,
    output logic [`DAT_W-1:0] legacy_descriptor_out,
    output logic [`DAT_W-1:0] output_data_rate_out
);
    ////////////////////////////////////////////////////////////////////
    logic [`DAT_W-1:0] bus_capability_byte;
    logic [`DAT_W-1:0] device_type_byte;
    logic [`DAT_W-1:0] legacy_device_descriptor;
    logic [`DAT_W-1:0] output_data_rate;
    logic [1:0] int_status;
    logic [1:0] int_enable;
    logic tx_empty_q;
    logic rx_full_q;
    logic [`DAT_W-1:0] next_rdata;
    logic do_write;
    logic do_read;

    // legacy bytes with a reserved index are forced to zero
    function automatic logic [`DAT_W-1:0] clean_legacy(
        input logic [`DAT_W-1:0] raw);
        logic [`DAT_W-1:0] v;
        v = `BYTE_ZERO;
        if (raw[`LEG_IDX_HI:`LEG_IDX_LO] <= `LEG_IDX_MAX) begin
            v[`LEG_IDX_HI:`LEG_IDX_LO] = raw[`LEG_IDX_HI:`LEG_IDX_LO];
            v[`LEG_MODE_BIT] = raw[`LEG_MODE_BIT];
        end
        return v;
    endfunction : clean_legacy

    // a request only counts while ready is high
    assign do_write = port.request && port.ready && port.wr_rdn;
    assign do_read = port.request && port.ready && !port.wr_rdn;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            bus_capability_byte <= `BUS_CAP_RST;
            device_type_byte <= `DEV_TYPE_RST;
        end else begin
            bus_capability_byte[`ROLE_HI:`ROLE_LO] <= ROLE;
            bus_capability_byte[`BIT_HDR] <= HDR_CAPABLE;
            bus_capability_byte[`BIT_BRIDGE] <= IS_BRIDGE;
            bus_capability_byte[`BIT_OFFLINE] <= OFFLINE_CAPABLE;
            bus_capability_byte[`BIT_IBI_PAYLOAD] <= IBI_PAYLOAD;
            bus_capability_byte[`BIT_IBI_REQ] <= IBI_CAPABLE;
            bus_capability_byte[`BIT_SPEED_LIM] <= SPEED_LIMITED;
            device_type_byte <= DEVICE_TYPE;
        end
    end

    // descriptor comes from the controlling entity, not the host port
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            legacy_device_descriptor <= `LEGACY_RST;
        end else if (legacy_load_in) begin
            legacy_device_descriptor <= clean_legacy(legacy_descriptor_in);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            output_data_rate <= `ODR_RST;
        end else begin
            output_data_rate <= output_data_rate_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            int_enable <= `INT_RST;
        end else if (do_write && port.offset == `OFS_INT_ENABLE) begin
            int_enable <= port.wdata[1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            // high so a flag already up at reset makes no false edge
            tx_empty_q <= `EDGE_Q_RST;
            rx_full_q <= `EDGE_Q_RST;
        end else begin
            tx_empty_q <= tx_empty_in;
            rx_full_q <= rx_full_in;
        end
    end

    // rising edge sets; write one clears; a set in the same cycle wins
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            int_status <= `INT_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (do_write && port.offset == `OFS_INT_STATUS &&
                    port.wdata[i]) begin
                    int_status[i] <= 1'b0;
                end
            end
            if (tx_empty_in && !tx_empty_q) begin
                int_status[`INT_TX_EMPTY] <= 1'b1;
            end
            if (rx_full_in && !rx_full_q) begin
                int_status[`INT_RX_FULL] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            port.irq <= 1'b0;
        end else begin
            port.irq <= |(int_status & int_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_rdata = `BYTE_ZERO;
        if (port.offset == `OFS_BUS_CAP) begin
            next_rdata = bus_capability_byte;
        end else if (port.offset == `OFS_DEV_TYPE) begin
            next_rdata = device_type_byte;
        end else if (port.offset == `OFS_LEGACY) begin
            next_rdata = legacy_device_descriptor;
        end else if (port.offset == `OFS_ODR) begin
            next_rdata = output_data_rate;
        end else if (port.offset == `OFS_INT_STATUS) begin
            next_rdata = {6'h00, int_status};
        end else if (port.offset == `OFS_INT_ENABLE) begin
            next_rdata = {6'h00, int_enable};
        end
    end

    // one wait state after each request; reads answer on that cycle
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            port.ready <= 1'b0;
            port.rdata_valid <= 1'b0;
            port.rdata <= `BYTE_ZERO;
        end else begin
            port.ready <= !(do_write || do_read);
            port.rdata_valid <= do_read;
            if (do_read) begin
                port.rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            bus_capability_out <= `BUS_CAP_RST;
            device_type_out <= `DEV_TYPE_RST;
            legacy_descriptor_out <= `LEGACY_RST;
            output_data_rate_out <= `ODR_RST;
        end else begin
            bus_capability_out <= bus_capability_byte;
            device_type_out <= device_type_byte;
            legacy_descriptor_out <= legacy_device_descriptor;
            output_data_rate_out <= output_data_rate;
        end
    end
endmodule : char_regs_device
`default_nettype wire

// ---- rtl/char_regs_host.sv ----
// host end: turns single user commands into native port transactions
`timescale 1ns/1ps
`default_nettype none
`include "char_regs_defs.svh"
module char_regs_host (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    char_port_if.host port,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [`OFS_W-1:0] cmd_offset_in,
    input wire logic [`DAT_W-1:0] cmd_wdata_in,
    output logic cmd_busy_out,
    output logic rsp_valid_out,
    output logic [`DAT_W-1:0] rsp_data_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////
    char_regs_pkg::host_state_e state;

    // request is held until the device shows ready high
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= char_regs_pkg::host_idle;
            port.request <= 1'b0;
            port.wr_rdn <= 1'b0;
            port.offset <= `OFS_BUS_CAP;
            port.wdata <= `BYTE_ZERO;
            cmd_busy_out <= 1'b1;
        end else begin
            case (state)
                char_regs_pkg::host_idle: begin
                    cmd_busy_out <= 1'b0;
                    if (cmd_valid_in) begin
                        port.request <= 1'b1;
                        port.wr_rdn <= cmd_write_in;
                        port.offset <= cmd_offset_in;
                        port.wdata <= cmd_wdata_in;
                        cmd_busy_out <= 1'b1;
                        state <= char_regs_pkg::host_wait_ready;
                    end
                end
                char_regs_pkg::host_wait_ready: begin
                    if (port.ready) begin
                        port.request <= 1'b0;
                        if (port.wr_rdn) begin
                            cmd_busy_out <= 1'b0;
                            state <= char_regs_pkg::host_idle;
                        end else begin
                            state <= char_regs_pkg::host_wait_data;
                        end
                    end
                end
                char_regs_pkg::host_wait_data: begin
                    if (port.rdata_valid) begin
                        cmd_busy_out <= 1'b0;
                        state <= char_regs_pkg::host_idle;
                    end
                end
                default: begin
                    state <= char_regs_pkg::host_idle;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= `BYTE_ZERO;
            irq_out <= 1'b0;
        end else begin
            rsp_valid_out <= state == char_regs_pkg::host_wait_data &&
                port.rdata_valid;
            if (port.rdata_valid) begin
                rsp_data_out <= port.rdata;
            end
            irq_out <= port.irq;
        end
    end
endmodule : char_regs_host
`default_nettype wire

// ---- tb/char_regs_sva.sv ----
// concurrent checks on the native characteristics register port
`timescale 1ns/1ps
`default_nettype none
`include "char_regs_defs.svh"
module char_regs_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic request,
    input wire logic wr_rdn,
    input wire logic [`OFS_W-1:0] offset,
    input wire logic [`DAT_W-1:0] wdata,
    input wire logic [`DAT_W-1:0] rdata,
    input wire logic rdata_valid,
    input wire logic ready,
    input wire logic irq
);
    // capability byte built from the default parameter set
    localparam logic [7:0] CAP_DEFAULT = 8'h67;
    logic rd_take;
    assign rd_take = request && ready && !wr_rdn;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    AST_READ_VALID: assert property (rd_take |=> rdata_valid)
        else $error("read take without valid pulse");
    AST_WRITE_SILENT: assert property (request && ready && wr_rdn
        |=> !rdata_valid) else $error("valid pulse after write");
    AST_VALID_CAUSE: assert property (rdata_valid |-> $past(rd_take))
        else $error("valid pulse without read take");
    AST_WAIT_STATE: assert property (request && ready
        |=> !ready ##1 ready) else $error("ready not low for one cycle");
    AST_HOST_HOLDS: assert property (request && !ready
        |=> request && $stable(wr_rdn) && $stable(offset)
        && $stable(wdata))
        else $error("host changed request during wait state");
    AST_RDATA_HOLDS: assert property (!rdata_valid |-> $stable(rdata))
        else $error("read data moved without valid");
    AST_CAP_VALUE: assert property (rd_take && offset == `OFS_BUS_CAP
        |=> rdata == CAP_DEFAULT) else $error("capability byte");
    AST_TYPE_VALUE: assert property (rd_take && offset == `OFS_DEV_TYPE
        |=> rdata == `DEV_TYPE_RST) else $error("device type byte");
    AST_UNMAPPED_ZERO: assert property (rd_take
        && offset > `OFS_INT_ENABLE |=> rdata == `BYTE_ZERO)
        else $error("unmapped read");
    AST_LEGACY_RSVD: assert property (rd_take && offset == `OFS_LEGACY
        |=> rdata[3:0] == 4'h0 && rdata[7:5] <= `LEG_IDX_MAX)
        else $error("legacy reserved field");
endmodule : char_regs_sva
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "char_regs_defs.svh"
module tb;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [8:0] cmd_offset = 9'h000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] legacy_in = 8'h00;
    logic legacy_load = 1'b0;
    logic tx_empty = 1'b0;
    logic rx_full = 1'b0;
    logic [7:0] odr_in = 8'h5a;
    logic busy, rsp_valid, irq_host;
    logic [7:0] rsp_data, cap_out, type_out, legacy_out, odr_out, rd;
    int err_count = 0;
    int comparisons = 0;
    // rows: write, offset, write data, expected read data
    localparam logic [25:0] ROWS [9] = '{
        {1'h0, 9'h000, 8'h00, 8'h67}, {1'h1, 9'h000, 8'hff, 8'h00},
        {1'h0, 9'h000, 8'h00, 8'h67}, {1'h1, 9'h001, 8'hff, 8'h00},
        {1'h0, 9'h001, 8'h00, 8'h00}, {1'h0, 9'h003, 8'h00, 8'h5a},
        {1'h1, 9'h005, 8'h03, 8'h00}, {1'h0, 9'h005, 8'h00, 8'h03},
        {1'h0, 9'h1ff, 8'h00, 8'h00}};
    char_port_if port ();
    char_regs_device i_char_regs_device (.mclk_in(mclk_in),
        .rst_n_in(rst_n_in), .port(port), .legacy_descriptor_in(legacy_in),
        .legacy_load_in(legacy_load), .tx_empty_in(tx_empty),
        .rx_full_in(rx_full), .output_data_rate_in(odr_in),
        .bus_capability_out(cap_out), .device_type_out(type_out),
        .legacy_descriptor_out(legacy_out), .output_data_rate_out(odr_out));
    char_regs_host i_char_regs_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .port(port), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
        .cmd_offset_in(cmd_offset), .cmd_wdata_in(cmd_wdata),
        .cmd_busy_out(busy), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .irq_out(irq_host));
    char_regs_sva i_char_regs_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .request(port.request), .wr_rdn(port.wr_rdn), .offset(port.offset),
        .wdata(port.wdata), .rdata(port.rdata),
        .rdata_valid(port.rdata_valid), .ready(port.ready), .irq(port.irq));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one command through the host end; read data lands in rd
    task automatic xfer(input logic wr, input logic [8:0] ofs,
            input logic [7:0] wd);
        int n;
        n = 0;
        rd = 8'hxx;
        cmd_write = wr;
        cmd_offset = ofs;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(negedge mclk_in);
        cmd_valid = 1'b0;
        forever begin
            if (rsp_valid === 1'b1) rd = rsp_data;
            if (busy === 1'b0 || n == 50) break;
            @(negedge mclk_in);
            n++;
        end
        check("busy", {7'h00, busy}, 8'h00);
    endtask : xfer
    task automatic wait_irq(input logic exp);
        repeat (4) @(negedge mclk_in);
        check("irq", {7'h00, irq_host}, {7'h00, exp});
    endtask : wait_irq
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        foreach (ROWS[i]) begin
            xfer(ROWS[i][25], ROWS[i][24:16], ROWS[i][15:8]);
            if (!ROWS[i][25]) check("table", rd, ROWS[i][7:0]);
        end
        check("cap out", cap_out, 8'h67);
        check("type out", type_out, 8'h00);
        check("odr out", odr_out, 8'h5a);
        $display("test table done");
        // bits 3:0 are dropped, a reserved index clears the byte
        legacy_in = 8'h5f;
        legacy_load = 1'b1;
        @(negedge mclk_in);
        legacy_load = 1'b0;
        xfer(1'b0, 9'h002, 8'h00);
        check("legacy", rd, 8'h50);
        check("legacy out", legacy_out, 8'h50);
        legacy_in = 8'h7f;
        legacy_load = 1'b1;
        @(negedge mclk_in);
        legacy_load = 1'b0;
        xfer(1'b0, 9'h002, 8'h00);
        check("legacy rsvd", rd, 8'h00);
        $display("test legacy done");
        tx_empty = 1'b1;
        wait_irq(1'b1);
        tx_empty = 1'b0;
        xfer(1'b1, 9'h004, 8'h01);
        wait_irq(1'b0);
        xfer(1'b1, 9'h005, 8'h01);
        rx_full = 1'b1;
        wait_irq(1'b0);
        xfer(1'b0, 9'h004, 8'h00);
        check("status", rd, 8'h02);
        xfer(1'b1, 9'h005, 8'h02);
        wait_irq(1'b1);
        $display("test irq done");
        rst_n_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("irq after reset", {7'h00, irq_host}, 8'h00);
        xfer(1'b0, 9'h005, 8'h00);
        check("enable after reset", rd, 8'h00);
        // rx full stayed high through reset: no edge may be seen
        xfer(1'b0, 9'h004, 8'h00);
        check("status after reset", rd, 8'h00);
        xfer(1'b0, 9'h000, 8'h00);
        check("cap after reset", rd, 8'h67);
        $display("test reset done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
